// >>> logic/aebx_exec.sv
// add, and and bit instruction datapath behind a classic wishbone slave
//
// Implementation choices: register access over Wishbone and the register offsets.
`timescale 1ns/1ps
module aebx_exec (
	input  wire logic        clk_i,
	input  wire logic        rst_i,
	input  wire logic        wb_cyc_i,
	input  wire logic        wb_stb_i,
	input  wire logic        wb_we_i,
	input  wire logic [9:0]  wb_adr_i,
	input  wire logic [3:0]  wb_sel_i,
	input  wire logic [31:0] wb_dat_i,
	output logic      [31:0] wb_dat_o,
	output logic             wb_ack_o,
	input  wire logic [7:0]  port_pins_i,
	output logic      [7:0]  port_latch_o,
	output logic             skip_o
);

	aebx_pkg::aebx_bus_state_t bus_q;
	aebx_pkg::aebx_bus_state_t bus_d;
	logic [31:0]               dat_q;
	logic [31:0]               dat_d;

	logic [7:0]                acc_q;
	logic [7:0]                acc_d;
	aebx_pkg::aebx_flags_t     flg_q;
	aebx_pkg::aebx_flags_t     flg_d;
	logic                      skip_q;
	logic                      skip_d;
	logic                      disc_q;
	logic                      disc_d;
	logic [13:0]               instr_q;
	logic [13:0]               instr_d;

	logic [7:0]                file_q [aebx_pkg::FILE_DEPTH];
	logic                      fw_en;
	logic [6:0]                fw_addr;
	logic [7:0]                fw_data;

	logic [7:0]                pin_s1_q;
	logic [7:0]                pin_s2_q;
	logic [7:0]                pin_s3_q;
	logic [7:0]                pin_q;
	logic [7:0]                pin_d;

	logic                      req;
	logic                      commit;
	logic                      in_file;
	aebx_pkg::aebx_instr_t     ins;
	logic [7:0]                fval;
	logic [8:0]                sum;
	logic [4:0]                nib;
	logic [7:0]                res;

	// pins come from outside the clock domain
	always_comb begin
		pin_d = pin_q;
		if (pin_s2_q == pin_s3_q) begin
			pin_d = pin_s3_q;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			pin_s1_q <= 8'h00;
			pin_s2_q <= 8'h00;
			pin_s3_q <= 8'h00;
			pin_q    <= 8'h00;
		end else begin
			pin_s1_q <= port_pins_i;
			pin_s2_q <= pin_s1_q;
			pin_s3_q <= pin_s2_q;
			pin_q    <= pin_d;
		end
	end

	assign req     = wb_cyc_i && wb_stb_i;
	// side effects happen only on the edge where the master sees ack
	assign commit  = req && (bus_q == aebx_pkg::BUS_ACK);
	assign in_file = wb_adr_i[9] == aebx_pkg::OFF_FILE[9];

	assign ins = aebx_pkg::aebx_decode(wb_dat_i[13:0]);
	// the port location reads back as the pin levels, not the latch
	assign fval = (ins.faddr == aebx_pkg::PORT_ADDR) ? pin_q
		: file_q[ins.faddr];
	assign nib  = {1'b0, acc_q[3:0]} + {1'b0, fval[3:0]};
	assign sum  = {1'b0, acc_q} + {1'b0, fval};

	always_comb begin
		bus_d   = aebx_pkg::BUS_IDLE;
		dat_d   = dat_q;
		acc_d   = acc_q;
		flg_d   = flg_q;
		skip_d  = skip_q;
		disc_d  = disc_q;
		instr_d = instr_q;
		fw_en   = 1'b0;
		fw_addr = wb_adr_i[8:2];
		fw_data = wb_dat_i[7:0];
		res     = 8'h00;
		if (req && bus_q == aebx_pkg::BUS_IDLE) begin
			bus_d = aebx_pkg::BUS_ACK;
			dat_d = 32'h0000_0000;
			if (in_file) begin
				dat_d[7:0] = file_q[wb_adr_i[8:2]];
			end else begin
				case (wb_adr_i)
					aebx_pkg::OFF_INSTR: begin
						dat_d[13:0] = instr_q;
					end
					aebx_pkg::OFF_ACC: begin
						dat_d[7:0] = acc_q;
					end
					aebx_pkg::OFF_STATUS: begin
						dat_d[2:0] = flg_q;
					end
					aebx_pkg::OFF_STATE: begin
						dat_d[1:0] = {disc_q, skip_q};
					end
					default: begin
						dat_d = 32'h0000_0000;
					end
				endcase
			end
		end
		if (commit && wb_we_i && wb_sel_i[0]) begin
			if (in_file) begin
				fw_en = 1'b1;
			end else if (wb_adr_i == aebx_pkg::OFF_ACC) begin
				acc_d = wb_dat_i[7:0];
			end else if (wb_adr_i == aebx_pkg::OFF_STATUS) begin
				flg_d = wb_dat_i[2:0];
			end else if (wb_adr_i == aebx_pkg::OFF_INSTR && wb_sel_i[1]) begin
				instr_d = wb_dat_i[13:0];
				disc_d  = skip_q;
				skip_d  = 1'b0;
				fw_addr = ins.faddr;
				// a skipped slot runs as a no-op: acc, flags and file keep their values
				if (!skip_q) begin
					case (ins.op)
						aebx_pkg::OP_ADD_LITERAL_TO_ACC: begin
							// nine bits wide so the carry is kept, not dropped
							{flg_d.c, res} = {1'b0, acc_q} + {1'b0, ins.lit};
							acc_d = res;
							flg_d.digit_carry_flag =
								({1'b0, acc_q[3:0]} + {1'b0, ins.lit[3:0]}) > 5'h0F;
							flg_d.z = res == 8'h00;
						end
						aebx_pkg::OP_ADD_ACC_AND_FILE: begin
							res     = sum[7:0];
							flg_d.c = sum[8];
							flg_d.digit_carry_flag = nib[4];
							flg_d.z = res == 8'h00;
							if (ins.dest_file) begin
								fw_en   = 1'b1;
								fw_data = res;
							end else begin
								acc_d = res;
							end
						end
						aebx_pkg::OP_AND_LITERAL_WITH_ACC: begin
							res     = acc_q & ins.lit;
							acc_d   = res;
							flg_d.z = res == 8'h00;
						end
						aebx_pkg::OP_AND_ACC_WITH_FILE: begin
							res     = acc_q & fval;
							flg_d.z = res == 8'h00;
							if (ins.dest_file) begin
								fw_en   = 1'b1;
								fw_data = res;
							end else begin
								acc_d = res;
							end
						end
						aebx_pkg::OP_BIT_CLEAR_FILE: begin
							fw_en   = 1'b1;
							fw_data = fval & ~(8'h01 << ins.bitpos);
						end
						aebx_pkg::OP_BIT_SET_FILE: begin
							fw_en   = 1'b1;
							fw_data = fval | (8'h01 << ins.bitpos);
						end
						aebx_pkg::OP_BIT_TEST_SKIP_WHEN_ZERO: begin
							skip_d = ~fval[ins.bitpos];
						end
						default: begin
							res = 8'h00;
						end
					endcase
				end
			end
		end
	end

	// all results land on one edge so the next instruction sees them
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			bus_q   <= aebx_pkg::BUS_IDLE;
			dat_q   <= 32'h0000_0000;
			acc_q   <= aebx_pkg::ACC_RST;
			flg_q   <= 3'h0;
			skip_q  <= 1'b0;
			disc_q  <= 1'b0;
			instr_q <= aebx_pkg::INSTR_RST;
		end else begin
			bus_q   <= bus_d;
			dat_q   <= dat_d;
			acc_q   <= acc_d;
			flg_q   <= flg_d;
			skip_q  <= skip_d;
			disc_q  <= disc_d;
			instr_q <= instr_d;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			for (int i = 0; i < aebx_pkg::FILE_DEPTH; i++) begin
				file_q[i] <= aebx_pkg::FILE_RST;
			end
		end else if (fw_en) begin
			file_q[fw_addr] <= fw_data;
		end
	end

	// one-hot state: bit 1 is the ack state, so ack is a bare flop
	assign wb_ack_o     = bus_q[1];
	assign wb_dat_o     = dat_q;
	assign port_latch_o = file_q[aebx_pkg::PORT_ADDR];
	assign skip_o       = skip_q;

endmodule

// >>> logic/aebx_pkg.sv
// constants, types and decode for the add and bit instruction datapath
// How it works
// - literal add puts acc plus an 8-bit literal in acc and updates all flags.
// - file add sums acc and file register f (0..127) into the chosen target.
// - destination bit 0 writes the result to acc, 1 writes it back to f.
// - literal and puts acc and literal in acc, touching only the zero flag.
// - file and routes acc and f to the chosen target, only z changes.
// - bit clear forces bit b of f to zero, nothing else changes.
// - bit set forces bit b of f to one, nothing else changes.
// - bit test skips the next instruction as a no-op when the bit is zero.
// - a port register used as its own source reads the pin levels.
package aebx_pkg;

	// wishbone byte addresses, one 32-bit word per register
	localparam logic [9:0] OFF_INSTR  = 10'h000;
	localparam logic [9:0] OFF_ACC    = 10'h004;
	localparam logic [9:0] OFF_STATUS = 10'h008;
	localparam logic [9:0] OFF_STATE  = 10'h00C;
	localparam logic [9:0] OFF_FILE   = 10'h200;
	localparam int unsigned FILE_DEPTH = 128;
	localparam logic [6:0] PORT_ADDR  = 7'h06;

	// status field positions and reset values
	localparam int unsigned ST_C  = 0;
	localparam int unsigned ST_DIGIT_CARRY_FLAG = 1;
	localparam int unsigned ST_Z  = 2;
	localparam logic [7:0] ACC_RST  = 8'h00;
	localparam logic [7:0] FILE_RST = 8'h00;
	localparam logic [13:0] INSTR_RST = 14'h0000;

	// opcode prefixes
	localparam logic [5:0] OPC_ADD_FILE = 6'h07;
	localparam logic [5:0] OPC_AND_FILE = 6'h05;
	localparam logic [5:0] OPC_AND_LIT  = 6'h39;
	localparam logic [4:0] OPC_ADD_LIT  = 5'h1F;
	localparam logic [3:0] OPC_BIT_CLR  = 4'h4;
	localparam logic [3:0] OPC_BIT_SET  = 4'h5;
	localparam logic [3:0] OPC_BIT_TST  = 4'h6;
	localparam int unsigned DEST_POS = 7;

	typedef enum logic [2:0] {
		OP_NONE,
		OP_ADD_LITERAL_TO_ACC,
		OP_ADD_ACC_AND_FILE,
		OP_AND_LITERAL_WITH_ACC,
		OP_AND_ACC_WITH_FILE,
		OP_BIT_CLEAR_FILE,
		OP_BIT_SET_FILE,
		OP_BIT_TEST_SKIP_WHEN_ZERO
	} aebx_op_t;

	typedef enum logic [1:0] {
		BUS_IDLE = 2'b01,
		BUS_ACK  = 2'b10
	} aebx_bus_state_t;

	typedef struct packed {
		logic z;
		logic digit_carry_flag;
		logic c;
	} aebx_flags_t;

	typedef struct packed {
		aebx_op_t   op;
		logic       dest_file;
		logic [2:0] bitpos;
		logic [6:0] faddr;
		logic [7:0] lit;
	} aebx_instr_t;

	function automatic aebx_instr_t aebx_decode(input logic [13:0] opc);
		aebx_instr_t r;
		r.op        = OP_NONE;
		r.dest_file = opc[DEST_POS];
		r.bitpos    = opc[9:7];
		r.faddr     = opc[6:0];
		r.lit       = opc[7:0];
		if (opc[13:9] == OPC_ADD_LIT) begin
			r.op = OP_ADD_LITERAL_TO_ACC;
		end else if (opc[13:8] == OPC_AND_LIT) begin
			r.op = OP_AND_LITERAL_WITH_ACC;
		end else if (opc[13:8] == OPC_ADD_FILE) begin
			r.op = OP_ADD_ACC_AND_FILE;
		end else if (opc[13:8] == OPC_AND_FILE) begin
			r.op = OP_AND_ACC_WITH_FILE;
		end else if (opc[13:10] == OPC_BIT_CLR) begin
			r.op = OP_BIT_CLEAR_FILE;
		end else if (opc[13:10] == OPC_BIT_SET) begin
			r.op = OP_BIT_SET_FILE;
		end else if (opc[13:10] == OPC_BIT_TST) begin
			r.op = OP_BIT_TEST_SKIP_WHEN_ZERO;
		end
		return r;
	endfunction

endpackage

// >>> tb/aebx_pin_model.sv
// external driver that holds the i/o port pins at a fixed level
`timescale 1ns/1ps
module aebx_pin_model #(
	parameter logic [7:0] LEVEL = 8'hA5
) (
	input  wire logic       clk_i,
	output logic      [7:0] pins_o
);
	initial pins_o = 8'h00;
	// nonblocking on the edge, like a register outside the block
	always @(posedge clk_i) pins_o <= LEVEL;
endmodule

// >>> tb/aebx_exec_monitor.sv
// assertion checker for the add and bit datapath ports
`timescale 1ns/1ps
module aebx_exec_monitor (
	input wire logic        clk_i,
	input wire logic        rst_i,
	input wire logic        wb_cyc_i,
	input wire logic        wb_stb_i,
	input wire logic        wb_we_i,
	input wire logic [9:0]  wb_adr_i,
	input wire logic [3:0]  wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	input wire logic [31:0] wb_dat_o,
	input wire logic        wb_ack_o,
	input wire logic [7:0]  port_pins_i,
	input wire logic [7:0]  port_latch_o,
	input wire logic        skip_o
);
	logic       iw;
	logic       ex;
	logic       bt_q;
	logic [2:0] pos_q;
	assign iw = wb_cyc_i && wb_stb_i && wb_ack_o && wb_we_i
		&& wb_adr_i == 10'h000 && wb_sel_i[1:0] == 2'h3;
	// a discarded instruction must not count as executed
	assign ex = iw && !skip_o;
	always_ff @(posedge clk_i) begin
		bt_q  <= ex && wb_dat_i[13:10] == 4'h6;
		pos_q <= wb_dat_i[9:7];
	end
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);
	sequence s_clr;
		ex && wb_dat_i[13:10] == 4'h4 && wb_dat_i[6:0] == 7'h06;
	endsequence
	sequence s_set;
		ex && wb_dat_i[13:10] == 4'h5 && wb_dat_i[6:0] == 7'h06;
	endsequence
	a_ack_after_req: assert property (
		wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o) else $error("ack late");
	a_ack_one_cycle: assert property (
		wb_ack_o |=> !wb_ack_o) else $error("ack too long");
	a_skip_cause: assert property (
		$rose(skip_o) |-> bt_q) else $error("skip without bit test");
	a_skip_consumed: assert property (
		iw && skip_o |=> !skip_o) else $error("skip not consumed");
	a_skip_holds: assert property (
		skip_o && !iw |=> skip_o) else $error("skip lost");
	a_port_clear: assert property (
		s_clr |=> !port_latch_o[pos_q]) else $error("port bit not cleared");
	a_port_set: assert property (
		s_set |=> port_latch_o[pos_q]) else $error("port bit not set");
	a_latch_quiet: assert property (
		!(wb_ack_o && wb_we_i) |=> $stable(port_latch_o))
		else $error("latch moved without a write");
endmodule
bind aebx_exec aebx_exec_monitor aebx_exec_monitor_inst (.clk_i(clk_i),
	.rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
	.wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
	.wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
	.port_pins_i(port_pins_i), .port_latch_o(port_latch_o), .skip_o(skip_o));

// >>> tb/aebx_exec_bench.sv
// self-checking bench for the add and bit datapath
`timescale 1ns/1ps
module aebx_exec_bench;
	logic        clk_i = 1'b0;
	logic        rst_i = 1'b1;
	logic        cyc = 1'b0;
	logic        we = 1'b0;
	logic [9:0]  adr = 10'h000;
	logic [31:0] dat = 32'h0, rdat, dout;
	logic        ack, skip;
	logic [7:0]  pins, latch;
	int          fails = 0, compares = 0, ticks = 0;
	aebx_exec aebx_exec_inst (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc),
		.wb_stb_i(cyc), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF),
		.wb_dat_i(dat), .wb_dat_o(dout), .wb_ack_o(ack),
		.port_pins_i(pins), .port_latch_o(latch), .skip_o(skip));
	aebx_pin_model aebx_pin_model_inst (.clk_i(clk_i), .pins_o(pins));
	initial forever #4 clk_i = ~clk_i;
	task automatic finish_test();
		if (fails == 0 && compares > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask
	// the whole run needs well under a thousand cycles
	always @(posedge clk_i) begin
		ticks <= ticks + 1;
		if (ticks == 3000) begin
			fails++;
			finish_test();
		end
	end
	task automatic chk(input string n, input logic [31:0] s, e);
		compares++;
		if (s !== e) begin
			fails++;
			$display("unexpected %s expected %h seen %h", n, e, s);
		end
	endtask
	task automatic x(input logic w, input logic [9:0] a, input logic [31:0] d);
		@(posedge clk_i);
		cyc <= 1'b1;
		we <= w;
		adr <= a;
		dat <= d;
		do @(posedge clk_i); while (ack !== 1'b1);
		rdat = dout;
		cyc <= 1'b0;
		we <= 1'b0;
	endtask
	task automatic r(input logic [9:0] a, input logic [31:0] e);
		x(1'b0, a, 32'h0);
		chk($sformatf("addr %h", a), rdat, e);
	endtask
	initial begin
		repeat (2) @(posedge clk_i);
		rst_i <= 1'b0;
		x(1'b1, 10'h004, 32'h88);
		x(1'b1, 10'h000, 32'h3E88);
		r(10'h004, 32'h10);
		r(10'h008, 32'h3);
		x(1'b1, 10'h000, 32'h3EF0);
		r(10'h008, 32'h5);
		x(1'b1, 10'h004, 32'h5A);
		x(1'b1, 10'h000, 32'h390F);
		r(10'h004, 32'h0A);
		r(10'h008, 32'h1);
		x(1'b1, 10'h240, 32'h22);
		x(1'b1, 10'h000, 32'h0710);
		r(10'h004, 32'h2C);
		r(10'h008, 32'h0);
		x(1'b1, 10'h000, 32'h0790);
		r(10'h240, 32'h4E);
		x(1'b1, 10'h000, 32'h0590);
		r(10'h240, 32'h0C);
		x(1'b1, 10'h008, 32'h3);
		x(1'b1, 10'h000, 32'h0511);
		r(10'h004, 32'h0);
		r(10'h008, 32'h7);
		for (int b = 0; b < 8; b++) begin
			x(1'b1, 10'h000, 32'h1412 | (b << 7));
			r(10'h248, (32'h2 << b) - 32'h1);
		end
		for (int b = 0; b < 8; b++) begin
			x(1'b1, 10'h000, 32'h1012 | (b << 7));
			r(10'h248, 32'hFE << b & 32'hFF);
		end
		r(10'h008, 32'h7);
		// pins differ from the latch, so the operand source shows
		x(1'b1, 10'h000, 32'h1486);
		r(10'h218, 32'hA7);
		x(1'b1, 10'h000, 32'h1006);
		r(10'h218, 32'hA4);
		chk("latch", {24'h0, latch}, 32'hA4);
		x(1'b1, 10'h000, 32'h1810);
		@(negedge clk_i);
		chk("skip", {31'h0, skip}, 32'h1);
		x(1'b1, 10'h000, 32'h3E01);
		r(10'h004, 32'h0);
		r(10'h00C, 32'h2);
		r(10'h008, 32'h7);
		x(1'b1, 10'h000, 32'h1910);
		x(1'b1, 10'h000, 32'h3E01);
		r(10'h004, 32'h1);
		r(10'h00C, 32'h0);
		r(10'h100, 32'h0);
		finish_test();
	end
endmodule
